// ### hdl/lhrrd_pkg.sv
// Constants and shared types of the high-resolution result readout
package lhrrd_pkg;

    // Register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_RESULT_LOW = 8'h38;
    localparam logic [ADDR_W-1:0] ADDR_RESULT_MID = 8'h39;
    localparam logic [ADDR_W-1:0] ADDR_RESULT_HIGH = 8'h3a;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h3b;
    localparam int DATA_W = 8;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

    // Status field positions
    localparam int STS_READY_N = 0;
    localparam int STS_OVERFLOW = 1;
    localparam int STS_UNDER_RANGE = 2;
    localparam int STS_OVER_RANGE = 3;
    localparam int STS_ZERO_COUNT = 4;
    localparam int STS_UNUSED_LSB = 5;
    localparam logic [2:0] STS_UNUSED_VALUE = 3'h0;

    // Result layout
    localparam int RESULT_W = 24;
    localparam int BYTE_MID_LSB = 8;
    localparam int BYTE_HIGH_LSB = 16;
    localparam int OFFSET_W = 16;
    localparam int OFFSET_SHIFT = RESULT_W - OFFSET_W;
    localparam int SCALE_SHIFT = 24;

    // Conversion timing in reference clock cycles
    localparam int REF_COUNT_W = 16;
    localparam int PERIOD_W = 21;
    localparam logic [PERIOD_W-1:0] CONV_MULT = 21'h00_0010;
    localparam logic [PERIOD_W-1:0] CONV_EXTRA = 21'h00_0037;
    localparam logic [REF_COUNT_W-1:0] REF_COUNT_MIN = 16'h0002;
    localparam int NUM_W = PERIOD_W + SCALE_SHIFT;

    // Sensor divider
    localparam int SENS_DIV_W = 2;
    localparam int SENS_PRE_W = 3;

    // Configuration carried into the block
    typedef struct packed {
        logic [REF_COUNT_W-1:0] ref_count;
        logic [OFFSET_W-1:0] offset;
        logic [SENS_DIV_W-1:0] sens_div;
    } lhrrd_cfg_t;

    // Error flags, ordered as in the status byte
    typedef struct packed {
        logic zero_count;
        logic over_range;
        logic under_range;
        logic overflow;
    } lhrrd_err_t;

    // Register read port from the serial interface logic
    typedef struct packed {
        logic rd;
        logic [ADDR_W-1:0] addr;
    } lhrrd_rd_t;

    // Conversion sequencer
    typedef enum logic [2:0] {
        LHRRD_IDLE = 3'h1,
        LHRRD_COUNT = 3'h2,
        LHRRD_DIVIDE = 3'h4
    } lhrrd_state_t;

endpackage : lhrrd_pkg

// ### hdl/lhrrd_sensor_tick.sv
// Sensor pin synchroniser and power-of-two divider
`timescale 1ns/1ps
module lhrrd_sensor_tick (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Sensor side
    input wire logic i_sensor_osc,
    input wire logic [lhrrd_pkg::SENS_DIV_W-1:0] i_div,
    // Divided edge pulse
    output logic o_tick
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [lhrrd_pkg::SENS_PRE_W-1:0] cnt;
        logic tick;
    } lhrrd_tick_st_t;

    lhrrd_tick_st_t st;
    lhrrd_tick_st_t next_st;
    logic rising;
    logic [lhrrd_pkg::SENS_PRE_W-1:0] mask;

    always_comb
    begin
        next_st = st;
        rising = st.sync2 & ~st.prev;
        // Divide by 1, 2, 4 or 8 for codes 0 to 3
        mask = 3'((4'h1 << i_div) - 4'h1);
        next_st.sync1 = i_sensor_osc;
        next_st.sync2 = st.sync1;
        next_st.prev = st.sync2;
        next_st.tick = 1'b0;
        if (rising)
        begin
            next_st.cnt = st.cnt + 3'h1;
            next_st.tick = ((st.cnt & mask) == mask);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_tick = st.tick;

endmodule : lhrrd_sensor_tick

// ### hdl/lhrrd_divider.sv
// Restoring divider, one quotient bit per cycle
`timescale 1ns/1ps
module lhrrd_divider #(
    parameter int NUM_W = 45,
    parameter int DEN_W = 21
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Request
    input wire logic i_start,
    input wire logic [NUM_W-1:0] i_num,
    input wire logic [DEN_W-1:0] i_den,
    // Answer
    output logic o_done,
    output logic [NUM_W-1:0] o_quot
);
    localparam int CNT_W = $clog2(NUM_W + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(NUM_W - 1);

    typedef struct packed {
        logic busy;
        logic done;
        logic [CNT_W-1:0] cnt;
        logic [DEN_W:0] rem;
        logic [DEN_W-1:0] den;
        logic [NUM_W-1:0] quo;
    } lhrrd_div_st_t;

    lhrrd_div_st_t st;
    lhrrd_div_st_t next_st;
    logic [DEN_W:0] shifted;

    always_comb
    begin
        next_st = st;
        next_st.done = 1'b0;
        shifted = {st.rem[DEN_W-1:0], st.quo[NUM_W-1]};
        if (i_start && !st.busy)
        begin
            next_st.busy = 1'b1;
            next_st.cnt = '0;
            next_st.rem = '0;
            next_st.den = i_den;
            next_st.quo = i_num;
        end
        else if (st.busy)
        begin
            next_st.quo = {st.quo[NUM_W-2:0], 1'b0};
            next_st.rem = shifted;
            if (shifted >= {1'b0, st.den})
            begin
                next_st.rem = shifted - {1'b0, st.den};
                next_st.quo[0] = 1'b1;
            end
            next_st.cnt = st.cnt + 1'b1;
            if (st.cnt == LAST)
            begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_done = st.done;
    assign o_quot = st.quo;

endmodule : lhrrd_divider

// ### hdl/lhrrd_readout.sv
// High-resolution inductance channel: conversion, result and status bytes
`timescale 1ns/1ps
module lhrrd_readout (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Configuration from the control registers
    input wire logic i_enable,
    input wire lhrrd_pkg::lhrrd_cfg_t i_cfg,
    // Sensor oscillator
    input wire logic i_sensor_osc,
    // Register read port
    input wire lhrrd_pkg::lhrrd_rd_t i_rd,
    output logic [lhrrd_pkg::DATA_W-1:0] o_rdata,
    // Live status
    output logic o_result_ready_n
);
    localparam int PW = lhrrd_pkg::PERIOD_W;
    localparam int RW = lhrrd_pkg::RESULT_W;
    localparam int NW = lhrrd_pkg::NUM_W;

    typedef struct packed {
        lhrrd_pkg::lhrrd_state_t fsm;
        logic [PW-1:0] ref_cnt;
        logic [PW-1:0] sens_cnt;
        logic [PW-1:0] period;
        logic start;
        logic [RW-1:0] result;
        lhrrd_pkg::lhrrd_err_t pend_err;
        lhrrd_pkg::lhrrd_err_t sts_err;
        logic ready_n;
        logic [RW-1:lhrrd_pkg::BYTE_MID_LSB] hold;
        logic [lhrrd_pkg::DATA_W-1:0] rdata;
    } lhrrd_top_st_t;

    lhrrd_top_st_t st;
    lhrrd_top_st_t next_st;

    logic tick;
    logic div_done;
    logic [NW-1:0] quot;
    logic [lhrrd_pkg::REF_COUNT_W-1:0] ref_count_eff;
    logic [RW:0] offset_ext;
    logic [RW:0] diff;
    logic rd_low;
    logic [lhrrd_pkg::DATA_W-1:0] status_byte;

    lhrrd_sensor_tick u_tick (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_sensor_osc(i_sensor_osc),
        .i_div(i_cfg.sens_div),
        .o_tick(tick)
    );

    lhrrd_divider #(
        .NUM_W(NW),
        .DEN_W(PW)
    ) u_div (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_start(st.start),
        .i_num({st.sens_cnt, {lhrrd_pkg::SCALE_SHIFT{1'b0}}}),
        .i_den(st.period),
        .o_done(div_done),
        .o_quot(quot)
    );

    always_comb
    begin
        next_st = st;
        next_st.start = 1'b0;
        rd_low = i_rd.rd && (i_rd.addr == lhrrd_pkg::ADDR_RESULT_LOW);
        // Counts below the legal floor behave as the floor
        ref_count_eff = (i_cfg.ref_count < lhrrd_pkg::REF_COUNT_MIN) ?
            lhrrd_pkg::REF_COUNT_MIN : i_cfg.ref_count;
        // Offset aligned to the top of the result word
        offset_ext = (RW + 1)'({i_cfg.offset,
            {lhrrd_pkg::OFFSET_SHIFT{1'b0}}});
        diff = {1'b0, quot[RW-1:0]} - offset_ext;
        status_byte = {lhrrd_pkg::STS_UNUSED_VALUE, st.sts_err,
            st.ready_n};

        // Read side: host access comes before the conversion update below
        if (i_rd.rd)
        begin
            unique case (i_rd.addr)
                lhrrd_pkg::ADDR_RESULT_LOW:
                    next_st.rdata = st.result[lhrrd_pkg::BYTE_MID_LSB-1:0];
                lhrrd_pkg::ADDR_RESULT_MID:
                    next_st.rdata = st.hold[lhrrd_pkg::BYTE_HIGH_LSB-1:
                        lhrrd_pkg::BYTE_MID_LSB];
                lhrrd_pkg::ADDR_RESULT_HIGH:
                    next_st.rdata = st.hold[RW-1:
                        lhrrd_pkg::BYTE_HIGH_LSB];
                lhrrd_pkg::ADDR_STATUS:
                    next_st.rdata = status_byte;
                default:
                    next_st.rdata = lhrrd_pkg::READ_UNMAPPED;
            endcase
        end
        if (rd_low)
        begin
            // Freeze upper bytes and flags of the result being returned
            next_st.hold = st.result[RW-1:lhrrd_pkg::BYTE_MID_LSB];
            next_st.sts_err = st.pend_err;
            next_st.ready_n = 1'b1;
        end

        unique case (st.fsm)
            lhrrd_pkg::LHRRD_IDLE:
            begin
                if (i_enable)
                begin
                    next_st.period = PW'(ref_count_eff) * lhrrd_pkg::CONV_MULT
                        + lhrrd_pkg::CONV_EXTRA;
                    next_st.ref_cnt = '0;
                    next_st.sens_cnt = '0;
                    next_st.fsm = lhrrd_pkg::LHRRD_COUNT;
                end
            end
            lhrrd_pkg::LHRRD_COUNT:
            begin
                if (tick)
                begin
                    next_st.sens_cnt = st.sens_cnt + 1'b1;
                end
                next_st.ref_cnt = st.ref_cnt + 1'b1;
                if (st.ref_cnt == st.period - 1'b1)
                begin
                    next_st.start = 1'b1;
                    next_st.fsm = lhrrd_pkg::LHRRD_DIVIDE;
                end
            end
            lhrrd_pkg::LHRRD_DIVIDE:
            begin
                if (div_done)
                begin
                    // Scaled ratio of divided sensor edges to window
                    next_st.pend_err.zero_count =
                        (st.sens_cnt == '0);
                    next_st.pend_err.over_range =
                        (st.sens_cnt > st.period);
                    next_st.pend_err.overflow =
                        (st.sens_cnt == st.period);
                    next_st.pend_err.under_range = diff[RW];
                    // Saturate rather than wrap so a bad code is obvious
                    if (st.sens_cnt >= st.period)
                    begin
                        next_st.result = '1;
                    end
                    else if (diff[RW])
                    begin
                        next_st.result = '0;
                    end
                    else
                    begin
                        next_st.result = diff[RW-1:0];
                    end
                    // Completion wins over a read in the same cycle
                    next_st.ready_n = 1'b0;
                    next_st.fsm = lhrrd_pkg::LHRRD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st <= '{fsm: lhrrd_pkg::LHRRD_IDLE, default: '0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_result_ready_n = st.ready_n;

    // Checks

    sequence s_read_low;
        i_rd.rd && (i_rd.addr == lhrrd_pkg::ADDR_RESULT_LOW);
    endsequence

    sequence s_ready_released;
        ##1 st.ready_n;
    endsequence

    sequence s_conv_done;
        div_done && st.fsm == lhrrd_pkg::LHRRD_DIVIDE;
    endsequence

    chk_low_byte_map: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        s_read_low |=> o_rdata == $past(st.result[7:0]))
        else $error("low byte read returned wrong data");

    chk_mid_from_hold: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        s_read_low ##1 (i_rd.rd && i_rd.addr == lhrrd_pkg::ADDR_RESULT_MID)
        |=> o_rdata == $past(st.result[15:8], 2))
        else $error("middle byte not from latched result");

    chk_ready_release: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (s_read_low and !(div_done && st.fsm == lhrrd_pkg::LHRRD_DIVIDE))
        |-> s_ready_released)
        else $error("ready flag not released by low byte read");

    chk_ready_on_done: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (div_done && st.fsm == lhrrd_pkg::LHRRD_DIVIDE) |=> !st.ready_n)
        else $error("ready flag not cleared at conversion end");

    chk_err_only_on_read: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !(i_rd.rd && i_rd.addr == lhrrd_pkg::ADDR_RESULT_LOW)
        |=> $stable(st.sts_err))
        else $error("error flags changed without low byte read");

    chk_zero_count: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (div_done && st.fsm == lhrrd_pkg::LHRRD_DIVIDE)
        |=> st.pend_err.zero_count == ($past(st.sens_cnt) == '0))
        else $error("zero count flag wrong");

    chk_conv_length: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (st.fsm == lhrrd_pkg::LHRRD_COUNT
            && $past(st.fsm) == lhrrd_pkg::LHRRD_COUNT
            && next_st.fsm == lhrrd_pkg::LHRRD_DIVIDE)
        |-> st.ref_cnt == st.period - 1'b1
            && st.period >= 21'h00_0057)
        else $error("conversion window length wrong");

    chk_status_unused: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_rd.rd && i_rd.addr == lhrrd_pkg::ADDR_STATUS)
        |=> o_rdata[7:5] == 3'h0
            && o_rdata[0] == $past(st.ready_n))
        else $error("status byte layout wrong");

    chk_under_range: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (div_done && st.fsm == lhrrd_pkg::LHRRD_DIVIDE && diff[RW])
        |=> st.pend_err.under_range && (st.result == '0
            || st.pend_err.overflow || st.pend_err.over_range))
        else $error("under-range not flagged");

    chk_high_from_hold: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        s_read_low ##1 (i_rd.rd && i_rd.addr == lhrrd_pkg::ADDR_RESULT_MID)
        ##1 (i_rd.rd && i_rd.addr == lhrrd_pkg::ADDR_RESULT_HIGH)
        |=> o_rdata == $past(st.result[23:16], 3))
        else $error("high byte not from latched result");

    chk_hold_stable: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !(i_rd.rd && i_rd.addr == lhrrd_pkg::ADDR_RESULT_LOW)
        |=> $stable(st.hold))
        else $error("held bytes changed without low byte read");

    chk_over_range: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        s_conv_done |=> st.pend_err.over_range
            == ($past(st.sens_cnt) > $past(st.period)))
        else $error("over-range flag wrong");

    chk_overflow: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        s_conv_done |=> st.pend_err.overflow
            == ($past(st.sens_cnt) == $past(st.period)))
        else $error("overflow flag wrong");

    chk_ready_held: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (!st.ready_n && !(i_rd.rd
            && i_rd.addr == lhrrd_pkg::ADDR_RESULT_LOW))
        |=> !st.ready_n)
        else $error("ready flag released without low byte read");

    chk_status_errs: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_rd.rd && i_rd.addr == lhrrd_pkg::ADDR_STATUS)
        |=> o_rdata[lhrrd_pkg::STS_ZERO_COUNT:lhrrd_pkg::STS_OVERFLOW]
            == $past(st.sts_err))
        else $error("status error bits misplaced");

endmodule : lhrrd_readout

// ### verification/lhrrd_host_model.sv
// Host partner model: register reads over the block's read port
`timescale 1ns/1ps
module lhrrd_host_model (
    // Clock
    input wire logic i_sys_clk,
    // Read port
    output lhrrd_pkg::lhrrd_rd_t o_rd,
    input wire logic [lhrrd_pkg::DATA_W-1:0] i_rdata
);
    initial o_rd = '0;

    // One read; the address is scrambled once the strobe drops
    task automatic read_reg(input logic [7:0] addr,
                            output logic [7:0] data);
        @(posedge i_sys_clk);
        o_rd <= '{rd: 1'b1, addr: addr};
        @(posedge i_sys_clk);
        o_rd <= '{rd: 1'b0, addr: ~addr};
        @(posedge i_sys_clk);
        data = i_rdata;
    endtask : read_reg

    // Low byte first, so the middle and high bytes belong to it;
    // three back-to-back strobes, each byte taken one edge later
    task automatic read_result(output logic [23:0] value);
        @(posedge i_sys_clk);
        o_rd <= '{rd: 1'b1, addr: lhrrd_pkg::ADDR_RESULT_LOW};
        @(posedge i_sys_clk);
        o_rd <= '{rd: 1'b1, addr: lhrrd_pkg::ADDR_RESULT_MID};
        @(posedge i_sys_clk);
        o_rd <= '{rd: 1'b1, addr: lhrrd_pkg::ADDR_RESULT_HIGH};
        value[7:0] = i_rdata;
        @(posedge i_sys_clk);
        o_rd <= '{rd: 1'b0, addr: ~lhrrd_pkg::ADDR_RESULT_HIGH};
        value[15:8] = i_rdata;
        @(posedge i_sys_clk);
        value[23:16] = i_rdata;
    endtask : read_result
endmodule : lhrrd_host_model

// ### verification/lhrrd_readout_tb.sv
// Self-checking bench of the high-resolution result readout
`timescale 1ns/1ps
module lhrrd_readout_tb;
    localparam int LIMIT = 30000;
    localparam int PERIOD = 2 * 16 + 55;
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_enable = 1'b0;
    lhrrd_pkg::lhrrd_cfg_t i_cfg = '{16'h0002, 16'h0000, 2'h0};
    logic i_sensor_osc = 1'b0;
    lhrrd_pkg::lhrrd_rd_t rd;
    logic [7:0] o_rdata;
    logic o_result_ready_n;
    logic sens_run = 1'b0;
    logic [1:0] sens_cnt = 2'h0;
    logic [7:0] d;
    logic [23:0] v;
    int cyc = 0;
    int n_errors = 0;
    int n_checks = 0;

    lhrrd_readout uut (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_enable(i_enable),
        .i_cfg(i_cfg),
        .i_sensor_osc(i_sensor_osc),
        .i_rd(rd),
        .o_rdata(o_rdata),
        .o_result_ready_n(o_result_ready_n)
    );

    lhrrd_host_model host (
        .i_sys_clk(i_sys_clk),
        .o_rd(rd),
        .i_rdata(o_rdata)
    );

    always #20 i_sys_clk = ~i_sys_clk;

    // Sensor: 8-cycle period while running, stuck low otherwise
    always @(posedge i_sys_clk)
    begin
        cyc <= cyc + 1;
        sens_cnt <= sens_cnt + 2'h1;
        if (!sens_run)
            i_sensor_osc <= 1'b0;
        else if (sens_cnt == 2'h3)
            i_sensor_osc <= ~i_sensor_osc;
        if (cyc == LIMIT)
        begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [23:0] seen,
                         input logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Edge counts shift by one with phase, so a window of counts passes
    function automatic logic in_range(input logic [23:0] val, input int dv,
                                      input int off);
        longint e;
        int n0;
        in_range = 1'b0;
        n0 = PERIOD / (8 << dv);
        for (int n = n0 - 1; n <= n0 + 1; n++)
        begin
            e = ((longint'(n) << 24) / PERIOD) - (longint'(off) << 8);
            if (e < 0)
                e = 0;
            if (n >= 0 && val === e[23:0])
                in_range = 1'b1;
        end
    endfunction : in_range

    task automatic wait_ready();
        for (int i = 0; i < 400; i++)
        begin
            @(posedge i_sys_clk);
            if (o_result_ready_n === 1'b0)
                return;
        end
        check("ready wait", 24'h1, 24'h0);
    endtask : wait_ready

    // Two completions after a change, so the result is of one setting only
    task automatic settle();
        host.read_reg(lhrrd_pkg::ADDR_RESULT_LOW, d);
        wait_ready();
        host.read_reg(lhrrd_pkg::ADDR_RESULT_LOW, d);
        wait_ready();
    endtask : settle

    task automatic set_cfg(input logic [15:0] rc, input logic [15:0] off,
                           input logic [1:0] dv);
        @(posedge i_sys_clk);
        i_cfg <= '{rc, off, dv};
        settle();
    endtask : set_cfg

    task automatic t_reset();
        check("ready in reset", {23'h0, o_result_ready_n}, 24'h0);
        check("rdata in reset", {16'h0, o_rdata}, 24'h0);
        @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        // Status before the low byte, whose read releases the ready flag
        for (int a = 8'h3c; a >= 8'h38; a--)
        begin
            host.read_reg(a[7:0], d);
            check("reset value", {16'h0, d}, 24'h0);
        end
    endtask : t_reset

    task automatic t_ready();
        @(posedge i_sys_clk);
        i_enable <= 1'b1;
        sens_run <= 1'b1;
        settle();
        host.read_reg(lhrrd_pkg::ADDR_STATUS, d);
        check("status unread", {16'h0, d}, 24'h0);
        host.read_reg(lhrrd_pkg::ADDR_RESULT_LOW, d);
        check("ready after low", {23'h0, o_result_ready_n}, 24'h1);
        host.read_reg(lhrrd_pkg::ADDR_STATUS, d);
        check("status read", {16'h0, d}, 24'h1);
    endtask : t_ready

    task automatic t_under();
        set_cfg(16'h0002, 16'hffff, 2'h0);
        host.read_result(v);
        check("under result", v, 24'h0);
        host.read_reg(lhrrd_pkg::ADDR_STATUS, d);
        check("under status", {16'h0, d}, 24'h5);
        set_cfg(16'h0002, 16'h1000, 2'h0);
        host.read_result(v);
        check("offset result", {23'h0, in_range(v, 0, 16'h1000)},
            24'h1);
        host.read_reg(lhrrd_pkg::ADDR_STATUS, d);
        check("status cleared", {16'h0, d}, 24'h1);
    endtask : t_under

    task automatic t_value();
        for (int dv = 0; dv < 4; dv++)
        begin
            set_cfg(16'h0002, 16'h0000, dv[1:0]);
            host.read_result(v);
            check("scaled result",
                {23'h0, in_range(v, dv, 0)}, 24'h1);
        end
    endtask : t_value

    // Reset in mid-run, after a read left nonzero data on the port
    task automatic t_midreset();
        @(posedge i_sys_clk);
        i_nrst <= 1'b0;
        @(posedge i_sys_clk);
        check("ready at rst", {23'h0, o_result_ready_n}, 24'h0);
        check("rdata at rst", {16'h0, o_rdata}, 24'h0);
        i_nrst <= 1'b1;
        host.read_reg(lhrrd_pkg::ADDR_RESULT_MID, d);
        check("hold at rst", {16'h0, d}, 24'h0);
        host.read_reg(lhrrd_pkg::ADDR_STATUS, d);
        check("status at rst", {16'h0, d}, 24'h0);
    endtask : t_midreset

    task automatic t_zero();
        logic [23:0] a;
        set_cfg(16'h0002, 16'h0000, 2'h0);
        host.read_result(a);
        @(posedge i_sys_clk);
        sens_run <= 1'b0;
        wait_ready();
        host.read_reg(lhrrd_pkg::ADDR_STATUS, d);
        check("flags held", {16'h0, d}, 24'h0);
        host.read_reg(lhrrd_pkg::ADDR_RESULT_MID, d);
        check("mid held", {16'h0, d}, {16'h0, a[15:8]});
        host.read_reg(lhrrd_pkg::ADDR_RESULT_HIGH, d);
        check("high held", {16'h0, d}, {16'h0, a[23:16]});
        host.read_reg(lhrrd_pkg::ADDR_RESULT_LOW, d);
        wait_ready();
        host.read_result(v);
        check("zero result", v, 24'h0);
        host.read_reg(lhrrd_pkg::ADDR_STATUS, d);
        check("zero status", {16'h0, d}, 24'h11);
        @(posedge i_sys_clk);
        sens_run <= 1'b1;
    endtask : t_zero

    // Cycles between two completions, reading the low byte in between
    task automatic measure(input logic [15:0] rc, output int t);
        int t0;
        set_cfg(rc, 16'h0000, 2'h0);
        t0 = cyc;
        host.read_reg(lhrrd_pkg::ADDR_RESULT_LOW, d);
        wait_ready();
        t = cyc - t0;
    endtask : measure

    task automatic t_timing();
        int t2;
        int t3;
        int t0;
        measure(16'h0002, t2);
        measure(16'h0003, t3);
        measure(16'h0000, t0);
        check("count step", 24'(t3 - t2), 24'h10);
        check("count floor", 24'(t0 - t2), 24'h0);
    endtask : t_timing

    task automatic wrap_up();
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (16) @(posedge i_sys_clk);
        t_reset();
        t_ready();
        t_under();
        t_value();
        t_midreset();
        t_zero();
        t_timing();
        wrap_up();
    end
endmodule : lhrrd_readout_tb
